// File: amp_mode_and_fault_supervisor.sv
module amp_mode_and_fault_supervisor #(
  parameter int unsigned BOOT_CNT    = amp_supervisor_pkg::BOOT_CYCLES,
  parameter int unsigned UNMUTE_CNT  = amp_supervisor_pkg::UNMUTE_CYCLES,
  parameter int unsigned DC_CNT      = amp_supervisor_pkg::DC_CYCLES,
  parameter int unsigned RESTART_CNT = amp_supervisor_pkg::RESTART_CYCLES
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_clk_en,
  input  wire logic       i_enable,              // enable pin
  input  wire logic       i_mute_pin_n,          // active-low mute pin
  input  wire logic       i_output_config_pin,   // 0 paralleled, 1 bridge
  input  wire logic       i_mute_source_reg,     // 1: mute follows bits
  input  wire logic [1:0] i_channel_silence_bits,
  input  wire logic [1:0] i_channel_off_bits,
  input  wire logic       i_standby,
  input  wire logic       i_paralleled_mode,
  input  wire logic       i_config_override_enable,
  input  wire logic [1:0] i_gain,
  input  wire logic       i_fault_clear_trigger,
  input  wire logic       i_pll_locked,          // synchronized indicators
  input  wire logic       i_level_high,
  input  wire logic [3:0] i_temp_audio_faults,   // low temp, audio, ote, otw
  input  wire logic       i_supply_overvoltage,
  input  wire logic       i_supply_undervoltage,
  input  wire logic       i_supply_lockout,
  input  wire logic [1:0] i_dc_over,
  input  wire logic [1:0] i_flycap_fault,
  input  wire logic [1:0] i_overcurrent,
  output logic [1:0]      o_channel_switch_en,
  output logic [1:0]      o_channel_audio_en,
  output logic            o_second_stage_en,
  output logic            o_two_channel_bridge_config,
  output logic [1:0]      o_gain,
  output logic            o_low_power,
  output logic            o_running,
  output logic            o_fault_pin_n_out,     // open-drain: always 0 data
  output logic            o_fault_pin_n_oe,      // high pulls the pin low
  output logic            o_fault_pin_status,
  output logic [amp_supervisor_pkg::GEN_W-1:0] o_live_fault_vector,
  output logic [amp_supervisor_pkg::GEN_W-1:0] o_general_fault_bits,
  output logic [amp_supervisor_pkg::CH_W-1:0]  o_chan0_fault_bits,
  output logic [amp_supervisor_pkg::CH_W-1:0]  o_chan1_fault_bits
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_meta_q;   // first stage, read only by second
  logic [2:0] pin_sync_q;   // enable, mute_n, config pin

  // two flops per asynchronous pin
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      pin_meta_q <= 3'h0;
      pin_sync_q <= 3'h0;
    end else if (i_clk_en) begin
      pin_meta_q <= {i_output_config_pin, i_mute_pin_n, i_enable};
      pin_sync_q <= pin_meta_q;
    end
  end

  wire logic enable_s = pin_sync_q[0];
  wire logic mute_n_s = pin_sync_q[1];
  wire logic config_s = pin_sync_q[2];

  // ----------------------------------------------------------------
  // counter helper
  // ----------------------------------------------------------------
  function automatic logic [31:0] count_down(input logic [31:0] v);
    count_down = (v == 32'h0000_0000) ? 32'h0000_0000 : v - 32'h0000_0001;
  endfunction : count_down

  // ----------------------------------------------------------------
  // run state: shutdown, boot, normal
  // ----------------------------------------------------------------
  amp_supervisor_pkg::run_state_type run_q;
  logic [31:0] boot_cnt_q;
  logic        config_latch_q;   // pin value caught at power-up

  // lockout also forces shutdown; leaving it reboots like power-on
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      run_q          <= amp_supervisor_pkg::ST_SHUTDOWN;
      boot_cnt_q     <= 32'h0000_0000;
      config_latch_q <= 1'b1;
    end else if (i_clk_en) begin
      if (!enable_s || i_supply_lockout) begin
        run_q          <= amp_supervisor_pkg::ST_SHUTDOWN;
      end else begin
        case (run_q)
          amp_supervisor_pkg::ST_SHUTDOWN: begin
            run_q          <= amp_supervisor_pkg::ST_BOOT;
            boot_cnt_q     <= 32'(BOOT_CNT);
            config_latch_q <= config_s;
          end
          amp_supervisor_pkg::ST_BOOT: begin
            boot_cnt_q <= count_down(boot_cnt_q);
            if (boot_cnt_q <= 32'h0000_0001) begin
              run_q <= amp_supervisor_pkg::ST_NORMAL;
            end
          end
          amp_supervisor_pkg::ST_NORMAL: begin
            run_q <= amp_supervisor_pkg::ST_NORMAL;
          end
          default: begin
            run_q <= amp_supervisor_pkg::ST_SHUTDOWN;
          end
        endcase
      end
    end
  end

  wire logic running = (run_q == amp_supervisor_pkg::ST_NORMAL);

  // ----------------------------------------------------------------
  // supply protection: overvoltage latch until its clear threshold
  // ----------------------------------------------------------------
  // comparator hysteresis lives in the analog side; here the indicator
  // stays high until the lower clear point, so no extra filter is used
  wire logic supply_stop = i_supply_overvoltage || i_supply_undervoltage;

  // ----------------------------------------------------------------
  // mute with delayed unmute, per channel
  // ----------------------------------------------------------------
  logic [1:0]  unmuted_q;
  logic [31:0] unmute_cnt_q [2];
  logic [1:0]  mute_req;

  // pin or bits, then forced by supply faults
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      mute_req[c] = i_mute_source_reg ? i_channel_silence_bits[c]
                                      : !mute_n_s;
      mute_req[c] = mute_req[c] || supply_stop || !running || i_standby;
    end
  end

  // mute at once, unmute only after the delay has run out
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      unmuted_q       <= 2'h0;
      unmute_cnt_q[0] <= 32'h0000_0000;
      unmute_cnt_q[1] <= 32'h0000_0000;
    end else if (i_clk_en) begin
      for (int c = 0; c < 2; c++) begin
        if (mute_req[c]) begin
          unmuted_q[c]    <= 1'b0;
          unmute_cnt_q[c] <= 32'(UNMUTE_CNT);
        end else if (!unmuted_q[c]) begin
          unmute_cnt_q[c] <= count_down(unmute_cnt_q[c]);
          unmuted_q[c]    <= (unmute_cnt_q[c] <= 32'h0000_0001);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // channel trip and automatic restart (dc and overcurrent)
  // ----------------------------------------------------------------
  amp_supervisor_pkg::chan_state_type chan_q [2];
  logic [31:0] dc_cnt_q    [2];
  logic [31:0] restart_q   [2];
  logic [1:0]  dc_trip_q;       // one-cycle event per channel
  logic [1:0]  oc_trip_q;

  // dc must persist a full 1 Hz period before tripping
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      for (int c = 0; c < 2; c++) begin
        chan_q[c]    <= amp_supervisor_pkg::CH_RUN;
        dc_cnt_q[c]  <= 32'h0000_0000;
        restart_q[c] <= 32'h0000_0000;
      end
      dc_trip_q <= 2'h0;
      oc_trip_q <= 2'h0;
    end else if (i_clk_en) begin
      for (int c = 0; c < 2; c++) begin
        dc_trip_q[c] <= 1'b0;
        oc_trip_q[c] <= 1'b0;
        dc_cnt_q[c]  <= i_dc_over[c] ? dc_cnt_q[c] + 32'h0000_0001 : 32'h0000_0000;
        case (chan_q[c])
          amp_supervisor_pkg::CH_RUN: begin
            if (i_overcurrent[c]) begin
              chan_q[c]    <= amp_supervisor_pkg::CH_TRIPPED;
              oc_trip_q[c] <= 1'b1;
            end else if (i_dc_over[c] && dc_cnt_q[c] >= 32'(DC_CNT)) begin
              chan_q[c]    <= amp_supervisor_pkg::CH_TRIPPED;
              dc_trip_q[c] <= 1'b1;
            end
          end
          amp_supervisor_pkg::CH_TRIPPED: begin
            chan_q[c]    <= amp_supervisor_pkg::CH_RESTART;
            restart_q[c] <= 32'(RESTART_CNT);
          end
          amp_supervisor_pkg::CH_RESTART: begin
            restart_q[c] <= count_down(restart_q[c]);
            if (restart_q[c] <= 32'h0000_0001) begin
              chan_q[c]   <= amp_supervisor_pkg::CH_RUN;
              dc_cnt_q[c] <= 32'h0000_0000;
            end
          end
          default: begin
            chan_q[c] <= amp_supervisor_pkg::CH_RUN;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // fault vectors and clear trigger
  // ----------------------------------------------------------------
  logic [amp_supervisor_pkg::GEN_W-1:0] live_d;
  logic [amp_supervisor_pkg::GEN_W-1:0] live_q;
  logic [amp_supervisor_pkg::GEN_W-1:0] gen_sticky_q;
  logic [amp_supervisor_pkg::CH_W-1:0]  ch_event [2];
  logic [amp_supervisor_pkg::CH_W-1:0]  ch_sticky_q [2];
  logic       trig_q;
  logic       trig_armed_q;   // saw 0->1, waiting for 1->0
  wire  logic clear_pulse = trig_armed_q && trig_q && !i_fault_clear_trigger;

  // instantaneous general vector, one bit per source
  always_comb begin
    live_d                                   = '0;
    live_d[amp_supervisor_pkg::GEN_LOW_TEMP] = i_temp_audio_faults[0];
    live_d[amp_supervisor_pkg::GEN_AUDIO_IN] = i_temp_audio_faults[1];
    live_d[amp_supervisor_pkg::GEN_PLL]      = !i_pll_locked;
    live_d[amp_supervisor_pkg::GEN_SUP_HIGH] = i_supply_overvoltage;
    live_d[amp_supervisor_pkg::GEN_SUP_LOW]  = i_supply_undervoltage;
    live_d[amp_supervisor_pkg::GEN_OTE]      = i_temp_audio_faults[2];
    live_d[amp_supervisor_pkg::GEN_OTW]      = i_temp_audio_faults[3];
    for (int c = 0; c < 2; c++) begin
      ch_event[c]                                = '0;
      ch_event[c][amp_supervisor_pkg::CH_DC]     = dc_trip_q[c];
      ch_event[c][amp_supervisor_pkg::CH_FLYCAP] = i_flycap_fault[c];
      ch_event[c][amp_supervisor_pkg::CH_OC]     = oc_trip_q[c];
    end
  end

  // trigger edge tracking
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      trig_q       <= 1'b0;
      trig_armed_q <= 1'b0;
    end else if (i_clk_en) begin
      trig_q <= i_fault_clear_trigger;
      if (!trig_q && i_fault_clear_trigger) begin
        trig_armed_q <= 1'b1;
      end else if (clear_pulse) begin
        trig_armed_q <= 1'b0;
      end
    end
  end

  // sticky vectors: a new event in the clear cycle survives
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      live_q         <= '0;
      gen_sticky_q   <= '0;
      ch_sticky_q[0] <= '0;
      ch_sticky_q[1] <= '0;
    end else if (i_clk_en) begin
      live_q       <= live_d;
      gen_sticky_q <= (clear_pulse ? '0 : gen_sticky_q) | live_d;
      for (int c = 0; c < 2; c++) begin
        ch_sticky_q[c] <= (clear_pulse ? '0 : ch_sticky_q[c]) | ch_event[c];
      end
    end
  end

  // ----------------------------------------------------------------
  // fault pin, valid only once pll has locked once
  // ----------------------------------------------------------------
  logic pll_seen_q;
  logic fault_q;

  // any live fault or a channel trip pulls the pin low
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      pll_seen_q <= 1'b0;
      fault_q    <= 1'b0;
    end else if (i_clk_en) begin
      if (i_pll_locked) begin
        pll_seen_q <= 1'b1;
      end
      fault_q <= pll_seen_q && ((|live_d) || (|dc_trip_q) || (|oc_trip_q)
                 || (|i_flycap_fault));
    end
  end

  // ----------------------------------------------------------------
  // output stage control and profile
  // ----------------------------------------------------------------
  wire logic bridge = (i_config_override_enable && running)
                      ? !i_paralleled_mode : config_latch_q;

  // registered outputs
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_channel_switch_en         <= 2'h0;
      o_channel_audio_en          <= 2'h0;
      o_second_stage_en           <= 1'b0;
      o_two_channel_bridge_config <= 1'b1;
      o_gain                      <= amp_supervisor_pkg::GAIN_RESET;
      o_low_power                 <= 1'b1;
      o_running                   <= 1'b0;
      o_fault_pin_n_out           <= 1'b0;
      o_fault_pin_n_oe            <= 1'b0;
      o_fault_pin_status          <= 1'b1;
      o_live_fault_vector         <= '0;
      o_general_fault_bits        <= '0;
      o_chan0_fault_bits          <= '0;
      o_chan1_fault_bits          <= '0;
    end else if (i_clk_en) begin
      for (int c = 0; c < 2; c++) begin
        // muted channels still switch for flying capacitor balance
        o_channel_switch_en[c] <= running && !i_standby && !supply_stop
                                  && !i_channel_off_bits[c]
                                  && chan_q[c] == amp_supervisor_pkg::CH_RUN;
        o_channel_audio_en[c]  <= unmuted_q[c] && !i_channel_off_bits[c]
                                  && chan_q[c] == amp_supervisor_pkg::CH_RUN;
      end
      o_second_stage_en           <= bridge || i_level_high;
      o_two_channel_bridge_config <= bridge;
      o_gain                      <= i_gain;
      o_low_power                 <= i_standby || !running;
      o_running                   <= running;
      o_fault_pin_n_out           <= 1'b0;
      o_fault_pin_n_oe            <= fault_q;
      o_fault_pin_status          <= !fault_q;
      o_live_fault_vector         <= live_q;
      o_general_fault_bits        <= gen_sticky_q;
      o_chan0_fault_bits          <= ch_sticky_q[0];
      o_chan1_fault_bits          <= ch_sticky_q[1];
    end
  end

endmodule : amp_mode_and_fault_supervisor

// File: amp_supervisor_pkg.sv
package amp_supervisor_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 10;          // core clock period
  localparam int unsigned BOOT_TIME_US    = 10;          // boot sequence length
  localparam int unsigned BOOT_CYCLES     = (BOOT_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned UNMUTE_TIME_MS  = 20;          // unmute delay
  localparam int unsigned UNMUTE_CYCLES   = (UNMUTE_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned DC_TIME_MS      = 1000;        // one period of 1 Hz
  localparam int unsigned DC_CYCLES       = (DC_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned RESTART_TIME_MS = 100;         // auto restart wait
  localparam int unsigned RESTART_CYCLES  = (RESTART_TIME_MS * 1000000) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // field layouts
  // ----------------------------------------------------------------
  localparam int unsigned GEN_W        = 7;  // general fault vector width
  localparam int unsigned GEN_LOW_TEMP = 0;
  localparam int unsigned GEN_AUDIO_IN = 1;
  localparam int unsigned GEN_PLL      = 2;
  localparam int unsigned GEN_SUP_HIGH = 3;
  localparam int unsigned GEN_SUP_LOW  = 4;
  localparam int unsigned GEN_OTE      = 5;
  localparam int unsigned GEN_OTW      = 6;
  localparam int unsigned CH_W         = 3;  // per channel fault width
  localparam int unsigned CH_DC        = 0;
  localparam int unsigned CH_FLYCAP    = 1;
  localparam int unsigned CH_OC        = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] GAIN_RESET = 2'h3;

  typedef enum logic [1:0] {
    ST_SHUTDOWN,
    ST_BOOT,
    ST_NORMAL
  } run_state_type;

  typedef enum logic [1:0] {
    CH_RUN,
    CH_TRIPPED,
    CH_RESTART
  } chan_state_type;

endpackage : amp_supervisor_pkg

// File: amp_supervisor_properties.sv
// ------------------------------------------------------------------
// port-level checks for the amplifier supervisor
// ------------------------------------------------------------------
module amp_supervisor_checker (
  input wire logic       i_core_clk,
  input wire logic       i_resetn,
  input wire logic       i_enable,
  input wire logic       i_mute_pin_n,
  input wire logic       i_mute_source_reg,
  input wire logic [1:0] i_channel_silence_bits,
  input wire logic [1:0] i_channel_off_bits,
  input wire logic       i_pll_locked,
  input wire logic       i_supply_overvoltage,
  input wire logic       i_supply_lockout,
  input wire logic [1:0] i_overcurrent,
  input wire logic       o_running,
  input wire logic [1:0] o_channel_switch_en,
  input wire logic [1:0] o_channel_audio_en,
  input wire logic       o_fault_pin_n_oe,
  input wire logic       o_fault_pin_status,
  input wire logic [6:0] o_live_fault_vector,
  input wire logic [2:0] o_chan0_fault_bits
);
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);
  logic lock_seen_q; // pll has locked at least once since reset
  // remembers the first lock; the fault pin means nothing before it
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) lock_seen_q <= 1'b0;
    else if (i_pll_locked) lock_seen_q <= 1'b1;
  end
  a_shutdown_stops_run: assert property ($fell(i_enable) |-> ##[1:6] !o_running)
    else $error("running did not stop after enable fell");
  a_pin_mute_fast: assert property (($fell(i_mute_pin_n) && !i_mute_source_reg)
    |-> ##[1:6] (o_channel_audio_en == 2'h0)) else $error("pin mute was slow");
  a_unmute_delayed: assert property (($rose(i_mute_pin_n) && !i_mute_source_reg
    && o_channel_audio_en == 2'h0) |-> (o_channel_audio_en == 2'h0) [*8])
    else $error("unmute came without its delay");
  a_bit_mute_chan: assert property ((i_mute_source_reg && i_channel_silence_bits[0]) [*3]
    |-> !o_channel_audio_en[0]) else $error("channel bit did not mute");
  a_off_no_switch: assert property (i_channel_off_bits[1] [*3] |-> !o_channel_switch_en[1])
    else $error("disabled channel still switching");
  a_lock_gates_pin: assert property (!lock_seen_q |-> !o_fault_pin_n_oe)
    else $error("fault pin pulled before first lock");
  a_status_mirrors_pin: assert property (o_fault_pin_n_oe [*3] |-> !o_fault_pin_status)
    else $error("status bit does not follow the pin");
  a_overvolt_mute: assert property (i_supply_overvoltage [*3] |->
    (o_channel_switch_en == 2'h0 && o_channel_audio_en == 2'h0 && o_live_fault_vector[3]))
    else $error("overvoltage did not stop the stage");
  a_lockout_stops_run: assert property (i_supply_lockout [*4] |-> !o_running)
    else $error("lockout left the device running");
  a_oc_trips_chan: assert property ((i_overcurrent[0] && o_running) |-> ##[1:3]
    (o_chan0_fault_bits[2] && !o_channel_switch_en[0])) else $error("overcurrent missed");
endmodule : amp_supervisor_checker

bind amp_mode_and_fault_supervisor amp_supervisor_checker amp_supervisor_checker_i (
  .i_core_clk, .i_resetn, .i_enable, .i_mute_pin_n, .i_mute_source_reg,
  .i_channel_silence_bits, .i_channel_off_bits, .i_pll_locked, .i_supply_overvoltage,
  .i_supply_lockout, .i_overcurrent, .o_running, .o_channel_switch_en, .o_channel_audio_en,
  .o_fault_pin_n_oe, .o_fault_pin_status, .o_live_fault_vector, .o_chan0_fault_bits);

// File: host_pins_model.sv
// ------------------------------------------------------------------
// host side of the control pins and the open-drain fault line
// ------------------------------------------------------------------
module host_pins_model (
  input  wire logic i_core_clk,
  input  wire logic i_cmd_enable,
  input  wire logic i_cmd_mute_n,
  input  wire logic i_cmd_config,
  input  wire logic i_fault_oe,
  input  wire logic i_fault_out,
  output logic      o_enable            = 1'b0,
  output logic      o_mute_pin_n        = 1'b1,
  output logic      o_output_config_pin = 1'b1,
  output logic      o_fault_line
);
  timeunit 1ns;
  timeprecision 1ps;
  // gpio writes land just after the edge
  always @(posedge i_core_clk) begin
    o_enable <= i_cmd_enable;
    o_mute_pin_n <= i_cmd_mute_n;
    // strap moves only while shut down, so the boot sees a settled level
    if (!i_cmd_enable && !o_enable) o_output_config_pin <= i_cmd_config;
  end
  // pull-up wins unless the device pulls the line
  assign o_fault_line = i_fault_oe ? i_fault_out : 1'b1;
endmodule : host_pins_model

// File: amp_mode_and_fault_supervisor_tb_top.sv
module amp_mode_and_fault_supervisor_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------------
  // short counts so the run stays brief
  // ------------------------------------------------------------------
  localparam int unsigned BOOT = 8, UNMUTE = 12, DC = 10, RESTART = 16;
  logic i_core_clk = 1'b0, i_resetn = 1'b0, i_clk_en = 1'b1, i_level_high = 1'b0;
  logic i_mute_source_reg = 1'b0, i_standby = 1'b0, i_paralleled_mode = 1'b0;
  logic i_config_override_enable = 1'b0, i_fault_clear_trigger = 1'b0, i_pll_locked = 1'b0;
  logic i_supply_overvoltage = 1'b0, i_supply_undervoltage = 1'b0, i_supply_lockout = 1'b0;
  logic [1:0] i_channel_silence_bits = 2'h0, i_channel_off_bits = 2'h0, i_gain = 2'h3;
  logic [1:0] i_dc_over = 2'h0, i_flycap_fault = 2'h0, i_overcurrent = 2'h0;
  logic [3:0] i_temp_audio_faults = 4'h0;
  logic cmd_enable = 1'b0, cmd_mute_n = 1'b1, cmd_config = 1'b1, fault_line;
  logic i_enable, i_mute_pin_n, i_output_config_pin, o_second_stage_en, o_running;
  logic o_two_channel_bridge_config, o_low_power, o_fault_pin_n_out, o_fault_pin_n_oe;
  logic o_fault_pin_status;
  logic [1:0] o_channel_switch_en, o_channel_audio_en, o_gain;
  logic [6:0] o_live_fault_vector, o_general_fault_bits;
  logic [2:0] o_chan0_fault_bits, o_chan1_fault_bits;
  int num_errors = 0, n_compared = 0, cycles = 0;
  amp_mode_and_fault_supervisor #(.BOOT_CNT(BOOT), .UNMUTE_CNT(UNMUTE), .DC_CNT(DC),
    .RESTART_CNT(RESTART)) amp_mode_and_fault_supervisor_i (.i_core_clk, .i_resetn,
    .i_clk_en, .i_enable, .i_mute_pin_n, .i_output_config_pin, .i_mute_source_reg,
    .i_channel_silence_bits, .i_channel_off_bits, .i_standby, .i_paralleled_mode,
    .i_config_override_enable, .i_gain, .i_fault_clear_trigger, .i_pll_locked, .i_level_high,
    .i_temp_audio_faults, .i_supply_overvoltage, .i_supply_undervoltage, .i_supply_lockout,
    .i_dc_over, .i_flycap_fault, .i_overcurrent, .o_channel_switch_en, .o_channel_audio_en,
    .o_second_stage_en, .o_two_channel_bridge_config, .o_gain, .o_low_power, .o_running,
    .o_fault_pin_n_out, .o_fault_pin_n_oe, .o_fault_pin_status, .o_live_fault_vector,
    .o_general_fault_bits, .o_chan0_fault_bits, .o_chan1_fault_bits);
  host_pins_model host_pins_model_i (.i_core_clk, .i_cmd_enable(cmd_enable),
    .i_cmd_mute_n(cmd_mute_n), .i_cmd_config(cmd_config), .i_fault_oe(o_fault_pin_n_oe),
    .i_fault_out(o_fault_pin_n_out), .o_enable(i_enable), .o_mute_pin_n(i_mute_pin_n),
    .o_output_config_pin(i_output_config_pin), .o_fault_line(fault_line));
  always #5 i_core_clk = ~i_core_clk;
  // hang guard; the whole run needs well under a thousand cycles
  always @(posedge i_core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors = num_errors + 1;
      close_out();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask : cyc
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // bounded wait for the running flag
  task automatic wait_run(input logic want);
    for (int k = 0; k < 60 && o_running !== want; k++) cyc(1);
    chk("running", 8'(want), 8'(o_running));
  endtask : wait_run
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_boot();
    chk("gain reset", 8'h03, 8'(o_gain));
    cyc(20);
    chk("held down", 8'h00, 8'(o_running));
    cmd_enable <= 1'b1;
    wait_run(1'b1);
    chk("bridge", 8'h01, 8'(o_two_channel_bridge_config));
    chk("prelock live", 8'h04, 8'(o_live_fault_vector));
    chk("prelock line", 8'h01, 8'(fault_line));
    i_pll_locked <= 1'b1;
    cyc(2);
    i_fault_clear_trigger <= 1'b1;
    cyc(2);
    i_fault_clear_trigger <= 1'b0;
    cyc(UNMUTE + 6);
    chk("start clear", 8'h00, 8'(o_general_fault_bits));
    chk("unmuted", 8'h03, 8'(o_channel_audio_en));
    cmd_mute_n <= 1'b0;
    cyc(7);
    chk("pin mute", 8'h00, 8'(o_channel_audio_en));
    chk("muted switching", 8'h03, 8'(o_channel_switch_en));
    cmd_mute_n <= 1'b1;
    cyc(UNMUTE - 2);
    chk("unmute wait", 8'h00, 8'(o_channel_audio_en));
    cyc(10);
    chk("unmute done", 8'h03, 8'(o_channel_audio_en));
    $display("test boot and mute done");
  endtask : t_boot
  task automatic t_bits_gain();
    i_mute_source_reg <= 1'b1;
    i_channel_silence_bits <= 2'h1;
    cyc(4);
    chk("bit mute", 8'h02, 8'(o_channel_audio_en));
    i_channel_off_bits <= 2'h2;
    i_channel_silence_bits <= 2'h3;
    cyc(4);
    chk("chan off", 8'h01, 8'(o_channel_switch_en));
    for (int g = 0; g < 4; g++) begin
      i_gain <= g[1:0];
      cyc(3);
      chk("gain", 8'(g), 8'(o_gain));
    end
    i_clk_en <= 1'b0;
    i_gain <= 2'h0;
    cyc(3);
    chk("frozen gain", 8'h03, 8'(o_gain));
    i_clk_en <= 1'b1;
    i_channel_off_bits <= 2'h0;
    i_channel_silence_bits <= 2'h0;
    i_mute_source_reg <= 1'b0;
    cyc(UNMUTE + 6);
    $display("test bits and gain done");
  endtask : t_bits_gain
  task automatic t_faults();
    i_temp_audio_faults <= 4'h1;
    cyc(3);
    chk("live lowtemp", 8'h01, 8'(o_live_fault_vector));
    i_temp_audio_faults <= 4'h0;
    i_supply_overvoltage <= 1'b1;
    cyc(5);
    chk("ov live", 8'h08, 8'(o_live_fault_vector));
    chk("ov switch", 8'h00, 8'(o_channel_switch_en));
    chk("fault line", 8'h00, 8'(fault_line));
    chk("pin status", 8'h00, 8'(o_fault_pin_status));
    i_supply_overvoltage <= 1'b0;
    i_supply_undervoltage <= 1'b1;
    cyc(5);
    chk("uv stage", 8'h00, 8'({o_channel_switch_en, o_channel_audio_en}));
    i_supply_undervoltage <= 1'b0;
    i_fault_clear_trigger <= 1'b1;
    cyc(4);
    chk("held on rise", 8'h19, 8'(o_general_fault_bits));
    i_fault_clear_trigger <= 1'b0;
    cyc(4);
    chk("cleared", 8'h00, 8'(o_general_fault_bits));
    chk("line free", 8'h01, 8'(fault_line));
    cyc(UNMUTE + 6);
    $display("test faults done");
  endtask : t_faults
  task automatic t_protect();
    i_dc_over <= 2'h2;
    cyc(DC - 2);
    chk("dc short", 8'h03, 8'(o_channel_switch_en));
    cyc(6);
    i_dc_over <= 2'h0;
    chk("dc trip", 8'h01, 8'(o_channel_switch_en));
    chk("dc sticky", 8'h01, 8'(o_chan1_fault_bits));
    cyc(RESTART + 4);
    chk("dc restart", 8'h03, 8'(o_channel_switch_en));
    i_overcurrent <= 2'h1;
    i_flycap_fault <= 2'h2;
    cyc(1);
    i_overcurrent <= 2'h0;
    i_flycap_fault <= 2'h0;
    cyc(3);
    chk("oc sticky", 8'h04, 8'(o_chan0_fault_bits));
    chk("flycap sticky", 8'h03, 8'(o_chan1_fault_bits));
    cyc(RESTART + 4);
    chk("oc restart", 8'h03, 8'(o_channel_switch_en));
    $display("test protection done");
  endtask : t_protect
  task automatic t_config();
    cmd_enable <= 1'b0;
    wait_run(1'b0);
    cmd_config <= 1'b0;
    cyc(3);
    cmd_enable <= 1'b1;
    wait_run(1'b1);
    chk("paralleled", 8'h00, 8'(o_two_channel_bridge_config));
    chk("stage idle", 8'h00, 8'(o_second_stage_en));
    i_config_override_enable <= 1'b1;
    cyc(4);
    chk("override", 8'h01, 8'(o_two_channel_bridge_config));
    i_config_override_enable <= 1'b0;
    i_standby <= 1'b1;
    i_level_high <= 1'b1;
    cyc(4);
    chk("pin rules", 8'h00, 8'(o_two_channel_bridge_config));
    chk("stage busy", 8'h01, 8'(o_second_stage_en));
    chk("standby", 8'h01, 8'(o_low_power));
    i_standby <= 1'b0;
    i_supply_lockout <= 1'b1;
    cyc(5);
    chk("lockout", 8'h00, 8'(o_running));
    i_supply_lockout <= 1'b0;
    wait_run(1'b1);
    $display("test config done");
  endtask : t_config
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  initial begin
    cyc(10);
    i_resetn <= 1'b1;
    t_boot();
    t_bits_gain();
    t_faults();
    t_protect();
    t_config();
    close_out();
  end
endmodule : amp_mode_and_fault_supervisor_tb_top
